// >>> core/anc_channel_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module anc_channel_fifo #(
    parameter int WIDTH     = 10,
    parameter int ADDR_BITS = 10
) (
    input  wire logic                 wr_clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 wr_rst_i,
    input  wire logic                 wr_en_i,
    input  wire logic [WIDTH-1:0]     wr_data_i,
    input  wire logic                 rd_clk_i,
    input  wire logic                 rd_rst_i,
    input  wire logic                 rd_en_i,
    output logic      [WIDTH-1:0]     rd_data_o,
    output logic                      empty_o,
    output logic      [ADDR_BITS:0]   level_o
);
    logic [WIDTH-1:0]   mem [0:(1<<ADDR_BITS)-1];
    logic [ADDR_BITS:0] wbin;
    logic [ADDR_BITS:0] next_wbin;
    logic [ADDR_BITS:0] wgray;
    logic [ADDR_BITS:0] wgray_meta;
    logic [ADDR_BITS:0] wgray_sync;
    logic [ADDR_BITS:0] wbin_sync;
    logic [ADDR_BITS:0] rbin;
    logic [ADDR_BITS:0] next_rbin;

    function automatic logic [ADDR_BITS:0] gray_to_bin(
        input logic [ADDR_BITS:0] g);
        logic [ADDR_BITS:0] b;
        b[ADDR_BITS] = g[ADDR_BITS];
        for (int i = ADDR_BITS - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // ----------------------------------------
    // write side, link clock
    // ----------------------------------------
    always_comb begin
        next_wbin = wbin;
        if (wr_rst_i) begin
            next_wbin = '0;
        end else if (wr_en_i) begin
            next_wbin = wbin + 1'b1;
        end
    end

    // gray copy changes one bit per step
    always_ff @(posedge wr_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wbin  <= '0;
            wgray <= '0;
        end else begin
            wbin  <= next_wbin;
            wgray <= next_wbin ^ (next_wbin >> 1);
        end
    end

    // index wraps at the depth of the array
    always_ff @(posedge wr_clk_i) begin
        if (wr_en_i && !wr_rst_i) begin
            mem[wbin[ADDR_BITS-1:0]] <= wr_data_i;
        end
    end

    // ----------------------------------------
    // read side, pixel clock
    // ----------------------------------------
    always_ff @(posedge rd_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wgray_meta <= '0;
            wgray_sync <= '0;
        end else begin
            wgray_meta <= wgray;
            wgray_sync <= wgray_meta;
        end
    end

    assign wbin_sync = gray_to_bin(wgray_sync);
    assign empty_o   = (wbin_sync == rbin);
    assign level_o   = wbin_sync - rbin;
    assign rd_data_o = mem[rbin[ADDR_BITS-1:0]];

    // no step past the last stored word
    always_comb begin
        next_rbin = rbin;
        if (rd_rst_i) begin
            next_rbin = '0;
        end else if (rd_en_i && !empty_o) begin
            next_rbin = rbin + 1'b1;
        end
    end

    always_ff @(posedge rd_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rbin <= '0;
        end else begin
            rbin <= next_rbin;
        end
    end

    a_write_step: assert property (
        @(posedge wr_clk_i) disable iff (rst_i)
        wr_en_i && !wr_rst_i |=> wbin == $past(wbin) + 1'b1
    ) else $error("write pointer did not step");

    a_read_hold: assert property (
        @(posedge rd_clk_i) disable iff (rst_i)
        !rd_en_i && !rd_rst_i |=> $stable(rbin)
    ) else $error("read pointer moved while idle");

    a_read_home: assert property (
        @(posedge rd_clk_i) disable iff (rst_i)
        rd_rst_i |=> rbin == '0
    ) else $error("read pointer not at start");
endmodule

`default_nettype wire

// >>> core/anc_fifo_mode_channel_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "anc_fifo_regs.svh"

// How it works
// - auto mode: pointer reset and read enable are made inside.
// - auto mode: stored words go out only during horizontal blanking.
// - external mode: reset and read enable come from the two pins.
// - channel high uses the luma fifo and stream, low the chroma.
// - video bits 19 to 10 form the luma word, 19 most significant.
// - each rising link clock edge with write enable low stores a word, except while the pointer reset is held.
// - each fifo holds 1024 words of ten bits.
// - pointer reset low returns read and write pointers to start.
// - read enable low steps the read pointer each pixel clock while the fifo is not empty.
module anc_fifo_mode_channel_select (
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_i,
    input  wire logic [3:0]                  avs_address_i,
    input  wire logic                        avs_read_i,
    input  wire logic                        avs_write_i,
    input  wire logic [31:0]                 avs_writedata_i,
    input  wire logic [3:0]                  avs_byteenable_i,
    output logic      [31:0]                 avs_readdata_o,
    output logic                             avs_waitrequest_o,
    input  wire anc_fifo_pkg::video_bus_type video_data_i,
    input  wire logic                        hblank_i,
    input  wire logic                        fifo_pointer_reset_n_i,
    input  wire logic                        fifo_read_enable_n_i,
    input  wire logic                        ancillary_write_clock_i,
    input  wire logic                        fifo_write_enable_n_i,
    input  wire anc_fifo_pkg::anc_word_type  ancillary_word_in_i,
    output anc_fifo_pkg::anc_word_type       luma_word_o,
    output anc_fifo_pkg::anc_word_type       chroma_word_o,
    output logic                             insert_active_o
);
    import anc_fifo_pkg::*;

    localparam int AB = `ANC_ADDR_BITS;

    bus_phase_type   phase;
    bus_phase_type   next_phase;
    logic            next_wait;
    logic [31:0]     next_rdata;
    logic [31:0]     reg_word;
    logic            insertion_mode_select;
    logic            ancillary_channel_select;
    logic            next_mode;
    logic            next_chan;
    logic            under_l;
    logic            under_c;
    logic            next_under_l;
    logic            next_under_c;

    logic            hblank_q;
    logic [4:0]      rst_cnt;
    logic [4:0]      next_rst_cnt;
    logic            ptr_rst;
    logic            ptr_rst_q;
    logic            rd_req;
    logic            rd_en_l;
    logic            rd_en_c;
    logic            ins_l;
    logic            ins_c;

    anc_word_type    rdata_l;
    anc_word_type    rdata_c;
    logic            empty_l;
    logic            empty_c;
    logic [AB:0]     level_l;
    logic [AB:0]     level_c;
    anc_word_type    next_luma;
    anc_word_type    next_chroma;

    logic            chan_meta;
    logic            chan_w;
    logic            prst_meta;
    logic            prst_w;
    logic            wr_en_l;
    logic            wr_en_c;

    // ----------------------------------------
    // register bus slave
    // ----------------------------------------

    // read mux for the three mapped words
    always_comb begin
        reg_word = 32'h0000_0000;
        case (avs_address_i)
            `ANC_CTRL_OFFSET: begin
                reg_word[`ANC_CTRL_MODE_BIT] = insertion_mode_select;
                reg_word[`ANC_CTRL_CHAN_BIT] = ancillary_channel_select;
            end
            `ANC_STATUS_OFFSET: begin
                reg_word[`ANC_STAT_LEMPTY_BIT] = empty_l;
                reg_word[`ANC_STAT_CEMPTY_BIT] = empty_c;
                reg_word[`ANC_STAT_LUNDER_BIT] = under_l;
                reg_word[`ANC_STAT_CUNDER_BIT] = under_c;
                reg_word[`ANC_STAT_PRST_BIT]   = ptr_rst_q;
            end
            `ANC_LEVEL_OFFSET: begin
                reg_word[AB:0] = level_l;
                reg_word[`ANC_LEVEL_CHROMA_LSB +: AB+1] = level_c;
            end
            default: begin
                reg_word = 32'h0000_0000;
            end
        endcase
    end

    // one wait cycle, then one answer cycle; keeps the
    // readdata flop away from the mux on the sample edge
    always_comb begin
        next_phase = phase;
        next_wait  = 1'b1;
        next_rdata = avs_readdata_o;
        next_mode  = insertion_mode_select;
        next_chan  = ancillary_channel_select;
        next_under_l = under_l | (rd_en_l & empty_l);
        next_under_c = under_c | (rd_en_c & empty_c);
        case (phase)
            BUS_WAIT: begin
                if (avs_read_i || avs_write_i) begin
                    next_phase = BUS_ANSWER;
                    next_wait  = 1'b0;
                    next_rdata = reg_word;
                end
            end
            BUS_ANSWER: begin
                next_phase = BUS_WAIT;
                if (avs_write_i && avs_byteenable_i[0]) begin
                    if (avs_address_i == `ANC_CTRL_OFFSET) begin
                        next_mode =
                            avs_writedata_i[`ANC_CTRL_MODE_BIT];
                        next_chan =
                            avs_writedata_i[`ANC_CTRL_CHAN_BIT];
                    end
                    // write one clears, a new underrun wins
                    if (avs_address_i == `ANC_STATUS_OFFSET) begin
                        next_under_l = (rd_en_l & empty_l) |
                            (under_l &
                             !avs_writedata_i[`ANC_STAT_LUNDER_BIT]);
                        next_under_c = (rd_en_c & empty_c) |
                            (under_c &
                             !avs_writedata_i[`ANC_STAT_CUNDER_BIT]);
                    end
                end
            end
            default: begin
                next_phase = BUS_WAIT;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase                    <= BUS_WAIT;
            avs_waitrequest_o        <= 1'b1;
            avs_readdata_o           <= 32'h0000_0000;
            insertion_mode_select    <= `ANC_CTRL_MODE_RESET;
            ancillary_channel_select <= `ANC_CTRL_CHAN_RESET;
            under_l                  <= 1'b0;
            under_c                  <= 1'b0;
        end else begin
            phase                    <= next_phase;
            avs_waitrequest_o        <= next_wait;
            avs_readdata_o           <= next_rdata;
            insertion_mode_select    <= next_mode;
            ancillary_channel_select <= next_chan;
            under_l                  <= next_under_l;
            under_c                  <= next_under_c;
        end
    end

    // ----------------------------------------
    // mode control, pixel clock
    // ----------------------------------------

    // auto reset is held long enough for the link side
    // to see it through its synchroniser
    always_comb begin
        next_rst_cnt = 5'h00;
        if (insertion_mode_select) begin
            if (hblank_q && !hblank_i) begin
                next_rst_cnt = `ANC_RST_HOLD;
            end else if (rst_cnt != 5'h00) begin
                next_rst_cnt = rst_cnt - 5'h01;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hblank_q  <= 1'b0;
            rst_cnt   <= 5'h00;
            ptr_rst_q <= 1'b0;
        end else begin
            hblank_q  <= hblank_i;
            rst_cnt   <= next_rst_cnt;
            ptr_rst_q <= ptr_rst;
        end
    end

    // pin controls count only in external mode
    assign ptr_rst = insertion_mode_select ?
        (rst_cnt != 5'h00) : !fifo_pointer_reset_n_i;
    assign rd_req = insertion_mode_select ?
        hblank_i : !fifo_read_enable_n_i;

    assign rd_en_l = rd_req & ancillary_channel_select & !ptr_rst;
    assign rd_en_c = rd_req & !ancillary_channel_select & !ptr_rst;
    assign ins_l   = rd_en_l & !empty_l;
    assign ins_c   = rd_en_c & !empty_c;

    // ----------------------------------------
    // stream split and insertion
    // ----------------------------------------

    // an empty fifo leaves the video word untouched
    always_comb begin
        next_luma   = video_data_i[`ANC_LUMA_MSB:`ANC_LUMA_LSB];
        next_chroma = video_data_i[`ANC_CHROMA_MSB:`ANC_CHROMA_LSB];
        if (ins_l) begin
            next_luma = rdata_l;
        end
        if (ins_c) begin
            next_chroma = rdata_c;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            luma_word_o     <= 10'h000;
            chroma_word_o   <= 10'h000;
            insert_active_o <= 1'b0;
        end else begin
            luma_word_o     <= next_luma;
            chroma_word_o   <= next_chroma;
            insert_active_o <= ins_l | ins_c;
        end
    end

    // ----------------------------------------
    // link clock side
    // ----------------------------------------

    // channel and pointer reset are levels: two flops each
    always_ff @(posedge ancillary_write_clock_i or posedge rst_i) begin
        if (rst_i) begin
            chan_meta <= 1'b0;
            chan_w    <= 1'b0;
            prst_meta <= 1'b0;
            prst_w    <= 1'b0;
        end else begin
            chan_meta <= ancillary_channel_select;
            chan_w    <= chan_meta;
            prst_meta <= ptr_rst_q;
            prst_w    <= prst_meta;
        end
    end

    assign wr_en_l = !fifo_write_enable_n_i & chan_w;
    assign wr_en_c = !fifo_write_enable_n_i & !chan_w;

    // ----------------------------------------
    // the two channel fifos
    // ----------------------------------------
    anc_channel_fifo #(
        .WIDTH     (10),
        .ADDR_BITS (AB)
    ) luma_fifo (
        .wr_clk_i  (ancillary_write_clock_i),
        .rst_i     (rst_i),
        .wr_rst_i  (prst_w),
        .wr_en_i   (wr_en_l),
        .wr_data_i (ancillary_word_in_i),
        .rd_clk_i  (sys_clk_i),
        .rd_rst_i  (ptr_rst),
        .rd_en_i   (rd_en_l),
        .rd_data_o (rdata_l),
        .empty_o   (empty_l),
        .level_o   (level_l)
    );

    anc_channel_fifo #(
        .WIDTH     (10),
        .ADDR_BITS (AB)
    ) chroma_fifo (
        .wr_clk_i  (ancillary_write_clock_i),
        .rst_i     (rst_i),
        .wr_rst_i  (prst_w),
        .wr_en_i   (wr_en_c),
        .wr_data_i (ancillary_word_in_i),
        .rd_clk_i  (sys_clk_i),
        .rd_rst_i  (ptr_rst),
        .rd_en_i   (rd_en_c),
        .rd_data_o (rdata_c),
        .empty_o   (empty_c),
        .level_o   (level_c)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking dflt_cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    a_auto_reset: assert property (
        insertion_mode_select && hblank_q && !hblank_i
        |=> ptr_rst [*8]
    ) else $error("auto pointer reset too short");

    a_hanc_only: assert property (
        insertion_mode_select && !hblank_i |=>
        !insert_active_o &&
        luma_word_o == $past(video_data_i[19:10])
    ) else $error("insertion outside blanking");

    a_ext_reset: assert property (
        !insertion_mode_select && !fifo_pointer_reset_n_i
        |-> ptr_rst && !ins_l && !ins_c
    ) else $error("external reset not obeyed");

    a_ext_read: assert property (
        !insertion_mode_select && !fifo_read_enable_n_i &&
        fifo_pointer_reset_n_i && ancillary_channel_select &&
        !empty_l |=> insert_active_o
    ) else $error("external read enable not obeyed");

    a_pins_ignored: assert property (
        insertion_mode_select && !hblank_i &&
        !fifo_read_enable_n_i |-> !ins_l && !ins_c
    ) else $error("auto mode followed read pin");

    a_luma_path: assert property (
        ins_l |=> luma_word_o == $past(rdata_l) &&
        chroma_word_o == $past(video_data_i[9:0])
    ) else $error("luma insertion went astray");

    a_chroma_path: assert property (
        ins_c |=> chroma_word_o == $past(rdata_c) &&
        luma_word_o == $past(video_data_i[19:10])
    ) else $error("chroma insertion went astray");

    // an attempt on the release edge would see outputs still in reset
    a_luma_split: assert property (
        !rst_i && !ins_l |=> luma_word_o == $past(video_data_i[19:10])
    ) else $error("luma word taken from wrong bits");

    a_chroma_split: assert property (
        !rst_i && !ins_c |=> chroma_word_o == $past(video_data_i[9:0])
    ) else $error("chroma word taken from wrong bits");

    a_bus_answer: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o &&
        phase == BUS_WAIT |=> !avs_waitrequest_o ##1 avs_waitrequest_o
    ) else $error("bus answer not one cycle");

    c_luma_insert: cover property (ins_l ##1 ins_l);
    c_chroma_insert: cover property (ins_c);
    c_auto_line: cover property (
        insertion_mode_select && hblank_q && !hblank_i);
    c_bus_write: cover property (avs_write_i && !avs_waitrequest_o);
endmodule

`default_nettype wire

// >>> core/anc_fifo_pkg.sv
`default_nettype none

package anc_fifo_pkg;
    typedef logic [9:0]  anc_word_type;
    typedef logic [19:0] video_bus_type;
    typedef enum logic {BUS_WAIT, BUS_ANSWER} bus_phase_type;
endpackage

`default_nettype wire

// >>> core/anc_fifo_regs.svh
`ifndef ANC_FIFO_REGS_SVH
`define ANC_FIFO_REGS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define ANC_CTRL_OFFSET   4'h0
`define ANC_STATUS_OFFSET 4'h4
`define ANC_LEVEL_OFFSET  4'h8

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define ANC_CTRL_MODE_BIT     0
`define ANC_CTRL_CHAN_BIT     1
`define ANC_CTRL_MODE_RESET   1'h0
`define ANC_CTRL_CHAN_RESET   1'h0
`define ANC_STAT_LEMPTY_BIT   0
`define ANC_STAT_CEMPTY_BIT   1
`define ANC_STAT_LUNDER_BIT   2
`define ANC_STAT_CUNDER_BIT   3
`define ANC_STAT_PRST_BIT     4
`define ANC_LEVEL_CHROMA_LSB  16

// ----------------------------------------
// video split and fifo geometry
// ----------------------------------------
`define ANC_LUMA_MSB     19
`define ANC_LUMA_LSB     10
`define ANC_CHROMA_MSB   9
`define ANC_CHROMA_LSB   0
`define ANC_ADDR_BITS    10

// ----------------------------------------
// timing counts (pixel clock cycles)
// ----------------------------------------
`define ANC_RST_HOLD     5'h10

`endif

// >>> verification/anc_writer_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// link-side writer of ancillary words
// ----------------------------------------
module anc_writer_model (
    output logic                       link_clk_o,
    output logic                       wen_n_o,
    output anc_fifo_pkg::anc_word_type word_o
);
    import anc_fifo_pkg::*;

    // link clock runs free: the design's sync stages need its edges
    initial begin
        link_clk_o = 1'b0;
        wen_n_o    = 1'b1;
        word_o     = 10'h155;
        #7;
        forever #15 link_clk_o = ~link_clk_o;
    end

    // one word per rising edge; word lines flip once idle so no stale value
    task automatic write_burst(input int n, input anc_word_type first);
        for (int i = 0; i < n; i++) begin
            @(posedge link_clk_o);
            wen_n_o <= 1'b0;
            word_o  <= first + anc_word_type'(i);
        end
        @(posedge link_clk_o);
        wen_n_o <= 1'b1;
        word_o  <= ~word_o;
    endtask
endmodule

`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
    miscompares++; $display("unexpected %0t got %h exp %h", $time, a, b); \
    end end

module tb_top;
    import anc_fifo_pkg::*;

    logic          sys_clk_i;
    logic          rst_i;
    logic [3:0]    adr;
    logic          rd;
    logic          wr;
    logic [31:0]   wdat;
    logic [31:0]   rdat;
    logic          wreq;
    video_bus_type vid;
    logic          hblank;
    logic          ptr_n;
    logic          ren_n;
    logic          lclk;
    logic          wen_n;
    anc_word_type  aword;
    anc_word_type  luma;
    anc_word_type  chroma;
    logic          ins;
    int            miscompares;
    int            cmp_count;
    anc_word_type  got[$];
    logic [31:0]   rv;

    anc_writer_model u_writer (
        .link_clk_o(lclk),
        .wen_n_o   (wen_n),
        .word_o    (aword)
    );

    anc_fifo_mode_channel_select u_dut (
        .sys_clk_i              (sys_clk_i),
        .rst_i                  (rst_i),
        .avs_address_i          (adr),
        .avs_read_i             (rd),
        .avs_write_i            (wr),
        .avs_writedata_i        (wdat),
        .avs_byteenable_i       (4'hF),
        .avs_readdata_o         (rdat),
        .avs_waitrequest_o      (wreq),
        .video_data_i           (vid),
        .hblank_i               (hblank),
        .fifo_pointer_reset_n_i (ptr_n),
        .fifo_read_enable_n_i   (ren_n),
        .ancillary_write_clock_i(lclk),
        .fifo_write_enable_n_i  (wen_n),
        .ancillary_word_in_i    (aword),
        .luma_word_o            (luma),
        .chroma_word_o          (chroma),
        .insert_active_o        (ins)
    );

    // ----------------------------------------
    // clock, verdict, watchdog
    // ----------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    task automatic wrap_up();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // whole run needs well under this many cycles
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        miscompares++;
        wrap_up();
    end

    // ----------------------------------------
    // bus and stream helpers
    // ----------------------------------------
    // request held until the edge that sees waitrequest low;
    // only the watchdog ends a wait that never gets an answer
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk_i);
        adr  <= a;
        wr   <= w;
        rd   <= ~w;
        wdat <= d;
        do begin
            @(posedge sys_clk_i);
        end while (wreq !== 1'b0);
        rv = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    // gather inserted words of one stream over a span of cycles
    task automatic drain(input logic lum, input int cycles);
        got.delete();
        repeat (cycles) begin
            @(posedge sys_clk_i);
            if (ins === 1'b1) got.push_back(lum ? luma : chroma);
        end
    endtask

    task automatic expect_seq(input int n, input anc_word_type first);
        `CHK(got.size(), n)
        for (int i = 0; i < got.size() && i < n; i++) begin
            `CHK(got[i], first + anc_word_type'(i))
        end
    endtask

    task automatic ptr_pulse();
        @(posedge sys_clk_i);
        ptr_n <= 1'b0;
        repeat (20) @(posedge sys_clk_i);
        ptr_n <= 1'b1;
        // link side lets go of its reset two link edges later
        repeat (16) @(posedge sys_clk_i);
    endtask

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        miscompares = 0;
        cmp_count   = 0;
        rst_i  = 1'b1;
        adr    = 4'h0;
        rd     = 1'b0;
        wr     = 1'b0;
        wdat   = 32'h0;
        vid    = 20'hA5C3F;
        hblank = 1'b1;
        ptr_n  = 1'b1;
        ren_n  = 1'b1;
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        // video split, one cycle latency
        repeat (3) @(posedge sys_clk_i);
        `CHK(luma, vid[19:10])
        `CHK(chroma, vid[9:0])
        bus(1'b0, 4'h0, 32'h0);
        `CHK(rv[1:0], 2'h0)
        bus(1'b0, 4'hC, 32'h0);
        `CHK(rv, 32'h0)
        // external mode, chroma: nothing leaves while read enable is high
        ptr_pulse();
        u_writer.write_burst(3, 10'h1A0);
        drain(1'b0, 12);
        expect_seq(0, 10'h1A0);
        ren_n <= 1'b0;
        drain(1'b0, 12);
        expect_seq(3, 10'h1A0);
        ren_n <= 1'b1;
        // words written before a pointer reset are lost
        u_writer.write_burst(2, 10'h250);
        ptr_pulse();
        u_writer.write_burst(1, 10'h2C0);
        repeat (8) @(posedge sys_clk_i);
        ren_n <= 1'b0;
        drain(1'b0, 12);
        expect_seq(1, 10'h2C0);
        ren_n <= 1'b1;
        // luma channel selected
        bus(1'b1, 4'h0, 32'h2);
        ptr_pulse();
        u_writer.write_burst(2, 10'h3F0);
        repeat (8) @(posedge sys_clk_i);
        ren_n <= 1'b0;
        drain(1'b1, 12);
        expect_seq(2, 10'h3F0);
        ren_n <= 1'b1;
        // full depth: 1024 words fit and none is overwritten
        ptr_pulse();
        u_writer.write_burst(1024, 10'h000);
        repeat (8) @(posedge sys_clk_i);
        bus(1'b0, 4'h8, 32'h0);
        `CHK(rv[10:0], 11'h400)
        ren_n <= 1'b0;
        drain(1'b1, 1040);
        expect_seq(1024, 10'h000);
        ren_n <= 1'b1;
        // automatic mode: pins ignored, insertion only in blanking
        bus(1'b1, 4'h0, 32'h3);
        hblank <= 1'b0;
        repeat (40) @(posedge sys_clk_i);
        ptr_n <= 1'b0;
        ren_n <= 1'b0;
        u_writer.write_burst(4, 10'h100);
        drain(1'b1, 20);
        expect_seq(0, 10'h100);
        hblank <= 1'b1;
        drain(1'b1, 15);
        expect_seq(4, 10'h100);
        ptr_n <= 1'b1;
        ren_n <= 1'b1;
        bus(1'b0, 4'h0, 32'h0);
        `CHK(rv[1:0], 2'h3)
        bus(1'b0, 4'h4, 32'h0);
        `CHK(rv[2], 1'b1)
        wrap_up();
    end
endmodule

`default_nettype wire
